// >>> src/sync_serial_adapter.sv
// Status, control and register decode of a synchronous serial adapter,
// plus a small generic FIFO used in the receive path.
// Assumes the shifters and sync search run on clk and pins are async.
//
// How it works
// - Transmit avail: stage one empty, or one and two
// - Transmit reset blocks avail, clears FIFO once
// - Clear-to-send blocks avail unless external sync
// - Carrier rise latched; status-then-data read clears
// - Clear-to-send rise latched; command or reset clears
// - Underflow with sync fill sets flag and pulse
// - Underflow sends sync code, else all ones
// - Overrun on arrival while receive path full
// - Parity fault follows last stage, cleared by read
// - Status bit seven mirrors interrupt output
// - Three enables gate data and error interrupts
// - Select, direction and address control decode the seven registers
// - Word select gives length and parity
// - Transfer size bit picks one or two bytes
// - Two bits steer match / terminal ready pin
// - Clear sync pulse; strip drops sync characters
// - Section reset bits hold shifters in reset
// - Sync mode: one/two sync, external/internal
// - Data write or read drops its avail flag
// - Receive avail: last stage, or last two
// - Three byte stages shift on strobe pulses
// - Underflow pulse spans one transmit clock high
// - Status read clears no flag; it arms the data-read clear
`include "serial_adapter_params.svh"
`default_nettype none

module sync_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_r;
  logic [AW-1:0] rdPtr_r;
  logic [AW:0] count_r;
  logic push;
  logic pop;

  // Honest full and empty from the occupancy count
  assign inReady = count_r != (AW+1)'(DEPTH);
  assign outValid = count_r != '0;
  assign outData = mem[rdPtr_r];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  // Storage
  always_ff @(posedge clk) begin
    if (ce && push) begin
      mem[wrPtr_r] <= inData;
    end
  end

  // Pointers wrap at the depth
  always_ff @(posedge clk) begin
    if (rst) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end else if (ce) begin
      if (push) begin
        wrPtr_r <= (wrPtr_r == AW'(DEPTH-1)) ? '0 : wrPtr_r + 1'b1;
      end
      if (pop) begin
        rdPtr_r <= (rdPtr_r == AW'(DEPTH-1)) ? '0 : rdPtr_r + 1'b1;
      end
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

module sync_serial_adapter (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Host bus pins
  input wire logic busEnable,
  input wire logic chipSelectN,
  input wire logic registerSelect,
  input wire logic readNotWrite,
  input wire logic [7:0] dataIn,
  output logic [7:0] dataOut,
  output logic dataOe,
  // Open-drain interrupt, active low
  output logic irqOut,
  output logic irqOe,
  // Link pins
  input wire logic txClk,
  input wire logic rxClk,
  input wire logic carrierDetect,
  input wire logic clearToSendIn,
  output logic underflowOut,
  output logic matchOrTermReadyOut,
  // Shifter side, same clock
  input wire logic rxCharValid,
  input wire serial_adapter_pkg::rxChar_t rxChar,
  output logic rxCharReady,
  input wire logic syncMatch,
  input wire logic txTake,
  output logic [7:0] txCharOut,
  output serial_adapter_pkg::linkCtl_t linkCtl
);

  // Pin synchronisers and edge history
  serial_adapter_pkg::pins_t pinMeta_r;
  serial_adapter_pkg::pins_t pin_r;
  serial_adapter_pkg::pins_t pinPrev_r;
  // Registers
  logic [7:0] control_one_r;
  logic [7:0] control_two_r;
  logic [7:0] control_three_r;
  logic [7:0] syncPattern_r;
  logic clearSync_r;
  // Stage FIFOs
  serial_adapter_pkg::stages_t rxFifo_r;
  serial_adapter_pkg::stages_t rxFifo_nxt;
  serial_adapter_pkg::stages_t txFifo_r;
  serial_adapter_pkg::stages_t txFifo_nxt;
  // Flags
  logic dcdLatch_r;
  logic ctsLatch_r;
  logic txUnderflow_r;
  logic rxOverrun_r;
  logic statusSeen_r;
  logic smPulse_r;
  // Decode and misc
  logic eFall;
  logic access;
  logic hostRead;
  logic hostWrite;
  logic [1:0] addrCtl;
  logic wrC1;
  logic wrC2;
  logic wrC3;
  logic wrSync;
  logic wrTx;
  logic rdStatus;
  logic rdRx;
  logic txRstWrite;
  logic rxRstWrite;
  logic clrUfCmd;
  logic clrCtsCmd;
  logic txRst;
  logic rxRst;
  logic oneByte;
  logic rxDataAvail;
  logic txFifoAvail;
  logic parityError;
  logic irqAny;
  logic underflowEv;
  logic [7:0] status;
  logic [1:0] pcSel;
  logic bufValid;
  logic bufReady;
  logic [8:0] bufData;
  logic [8:0] rxFormatted;
  logic rxKeep;

  // Move each full stage into an empty neighbour, one hop per pulse
  function automatic serial_adapter_pkg::stages_t shiftStages(
      serial_adapter_pkg::stages_t s);
    serial_adapter_pkg::stages_t n;
    n = s;
    for (int i = `STAGE_N - 1; i > 0; i--) begin
      if (!n.full[i] && n.full[i-1]) begin
        n.full[i] = 1'b1;
        n.data[i] = n.data[i-1];
        n.full[i-1] = 1'b0;
      end
    end
    return n;
  endfunction

  // One-byte mode needs one stage, two-byte mode needs two
  function automatic logic transferReady(logic a, logic b, logic one);
    return one ? a : (a && b);
  endfunction

  // Mask unused bits and check parity for the selected format
  function automatic logic [8:0] formatChar(
      serial_adapter_pkg::rxChar_t c, logic [2:0] ws);
    logic [7:0] m;
    logic parityOn;
    m = c.data;
    parityOn = (ws != `WS_SEVEN_NP) && (ws != `WS_EIGHT_NP);
    if (ws[2:1] == 2'h0) begin
      m[7:6] = 2'h0;
    end else if (ws == `WS_SEVEN_NP || ws[2:1] == 2'h2) begin
      m[7] = 1'b0;
    end
    return {parityOn && ((^m ^ c.parityBit) != ws[0]), m};
  endfunction

  // Two flip-flops on every pin, then one for edge history
  always_ff @(posedge clk) begin
    if (rst) begin
      pinMeta_r <= '0;
      pin_r <= '0;
      pinPrev_r <= '0;
    end else if (ce) begin
      pinMeta_r <= {busEnable, chipSelectN, registerSelect, readNotWrite,
                    dataIn, txClk, rxClk, carrierDetect, clearToSendIn};
      pin_r <= pinMeta_r;
      pinPrev_r <= pin_r;
    end
  end

  // Access is taken at the strobe's falling edge, address held stable
  assign eFall = pinPrev_r.busEnable && !pin_r.busEnable;
  assign access = eFall && !pinPrev_r.chipSelectN;
  assign hostRead = access && pinPrev_r.readNotWrite;
  assign hostWrite = access && !pinPrev_r.readNotWrite;
  assign addrCtl = control_one_r[`C1_AC_HI:`C1_AC_LO];
  assign rdStatus = hostRead && !pinPrev_r.registerSelect;
  assign rdRx = hostRead && pinPrev_r.registerSelect;
  assign wrC1 = hostWrite && !pinPrev_r.registerSelect;
  assign wrC2 = hostWrite && pinPrev_r.registerSelect
                && addrCtl == `AC_FORMAT;
  assign wrC3 = hostWrite && pinPrev_r.registerSelect
                && addrCtl == `AC_SYNCMODE;
  assign wrSync = hostWrite && pinPrev_r.registerSelect
                  && addrCtl == `AC_SYNCCODE;
  assign wrTx = hostWrite && pinPrev_r.registerSelect
                && addrCtl == `AC_TXDATA;

  // Command strobes decoded from the written byte
  assign txRstWrite = wrC1 && pinPrev_r.dataIn[`C1_TXRST];
  assign rxRstWrite = wrC1 && pinPrev_r.dataIn[`C1_RXRST];
  assign clrUfCmd = wrC3 && pinPrev_r.dataIn[`C3_CLRUF];
  assign clrCtsCmd = wrC3 && pinPrev_r.dataIn[`C3_CLRCTS];
  assign txRst = control_one_r[`C1_TXRST];
  assign rxRst = control_one_r[`C1_RXRST];
  assign oneByte = control_two_r[`C2_ONEBYTE];
  assign pcSel = control_two_r[`C2_PC_HI:`C2_PC_LO];

  // Write-only control registers; command bits of the third self-clear
  always_ff @(posedge clk) begin
    if (rst) begin
      control_one_r <= `C1_RESET;
      control_two_r <= `C2_RESET;
      control_three_r <= `C3_RESET;
      syncPattern_r <= `SYNC_RESET;
    end else if (ce) begin
      if (wrC1) begin
        control_one_r <= pinPrev_r.dataIn;
      end
      if (wrC2) begin
        control_two_r <= pinPrev_r.dataIn;
      end
      if (wrC3) begin
        control_three_r <= {6'h00, pinPrev_r.dataIn[1:0]};
      end
      if (wrSync) begin
        syncPattern_r <= pinPrev_r.dataIn;
      end
    end
  end

  // Clear sync is a one-cycle pulse to the sync search
  always_ff @(posedge clk) begin
    if (rst) begin
      clearSync_r <= 1'b0;
    end else if (ce) begin
      clearSync_r <= wrC1 && pinPrev_r.dataIn[`C1_CLRSYNC];
    end
  end

  // Settings to the shifters come straight from registers
  assign linkCtl = '{txHoldReset: txRst,
                     rxHoldReset: rxRst,
                     clearSync: clearSync_r,
                     stripSync: control_one_r[`C1_STRIP],
                     wordSel: control_two_r[`C2_WS_HI:`C2_WS_LO],
                     oneSync: control_three_r[`C3_ONESYNC],
                     extSync: control_three_r[`C3_EXTSYNC],
                     fillWithSync: control_two_r[`C2_FILL],
                     syncCode: syncPattern_r};

  // Receive path: strip sync and check parity, then buffer
  assign rxFormatted = formatChar(rxChar, control_two_r[5:3]);
  assign rxKeep = rxCharValid && !rxRst
                  && !(control_one_r[`C1_STRIP] && rxChar.isSync);

  sync_fifo #(.WIDTH(9), .DEPTH(`BUF_DEPTH)) rxBuffer (
    .clk(clk),
    .rst(rst || rxRst),
    .ce(ce),
    .inValid(rxKeep),
    .inReady(bufReady),
    .inData(rxFormatted),
    .outValid(bufValid),
    .outReady(eFall && !rxFifo_r.full[0] && !rxRst),
    .outData(bufData)
  );

  // Stages advance on strobes; read empties the last stage first
  always_comb begin
    rxFifo_nxt = rxFifo_r;
    if (rdRx) begin
      rxFifo_nxt.full[`STAGE_N-1] = 1'b0;
    end
    if (eFall) begin
      rxFifo_nxt = shiftStages(rxFifo_nxt);
      if (!rxFifo_r.full[0] && bufValid) begin
        rxFifo_nxt.full[0] = 1'b1;
        rxFifo_nxt.data[0] = bufData;
      end
    end
    if (rxRst) begin
      rxFifo_nxt.full = '0;
    end
  end

  // Transmit stages: host loads the first, shifter drains the last
  always_comb begin
    txFifo_nxt = txFifo_r;
    if (txTake && !txRst) begin
      txFifo_nxt.full[`STAGE_N-1] = 1'b0;
    end
    if (eFall) begin
      txFifo_nxt = shiftStages(txFifo_nxt);
    end
    if (wrTx) begin
      txFifo_nxt.full[0] = 1'b1;
      txFifo_nxt.data[0] = {1'b0, pinPrev_r.dataIn};
    end
    if (txRstWrite) begin
      txFifo_nxt.full = '0;
    end
  end

  // Stage registers
  always_ff @(posedge clk) begin
    if (rst) begin
      rxFifo_r <= '0;
      txFifo_r <= '0;
    end else if (ce) begin
      rxFifo_r <= rxFifo_nxt;
      txFifo_r <= txFifo_nxt;
    end
  end

  // Next transmit character; fill on underflow
  assign underflowEv = txTake && !txRst && !txFifo_r.full[`STAGE_N-1];
  always_ff @(posedge clk) begin
    if (rst) begin
      txCharOut <= `MARK_CHAR;
    end else if (ce && txTake) begin
      if (txFifo_r.full[`STAGE_N-1]) begin
        txCharOut <= txFifo_r.data[`STAGE_N-1][7:0];
      end else if (control_two_r[`C2_FILL]) begin
        txCharOut <= syncPattern_r;
      end else begin
        txCharOut <= `MARK_CHAR;
      end
    end
  end

  // Availability flags; a read or write drops them at once
  assign rxDataAvail = transferReady(rxFifo_r.full[2],
                                     rxFifo_r.full[1], oneByte);
  assign txFifoAvail = !txRst
      && !(pin_r.clearToSendIn && !control_three_r[`C3_EXTSYNC])
      && transferReady(!txFifo_r.full[0], !txFifo_r.full[1],
                       oneByte);
  assign parityError = rxFifo_r.full[2] && rxFifo_r.data[2][8];

  // Status read arms the clear that the next data read performs
  always_ff @(posedge clk) begin
    if (rst) begin
      statusSeen_r <= 1'b0;
    end else if (ce) begin
      if (rdStatus) begin
        statusSeen_r <= 1'b1;
      end else if (rdRx || rxRst) begin
        statusSeen_r <= 1'b0;
      end
    end
  end

  // Sticky flags; a new event wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      dcdLatch_r <= 1'b0;
      ctsLatch_r <= 1'b0;
      txUnderflow_r <= 1'b0;
      rxOverrun_r <= 1'b0;
    end else if (ce) begin
      if (pin_r.carrierDetect && !pinPrev_r.carrierDetect) begin
        dcdLatch_r <= 1'b1;
      end else if ((rdRx && statusSeen_r) || rxRstWrite) begin
        dcdLatch_r <= 1'b0;
      end
      if (pin_r.clearToSendIn && !pinPrev_r.clearToSendIn) begin
        ctsLatch_r <= 1'b1;
      end else if (clrCtsCmd || txRstWrite) begin
        ctsLatch_r <= 1'b0;
      end
      if (underflowEv && control_two_r[`C2_FILL]) begin
        txUnderflow_r <= 1'b1;
      end else if (clrUfCmd || txRstWrite) begin
        txUnderflow_r <= 1'b0;
      end
      if (rxKeep && !bufReady) begin
        rxOverrun_r <= 1'b1;
      end else if ((rdRx && statusSeen_r) || rxRstWrite) begin
        rxOverrun_r <= 1'b0;
      end
    end
  end

  // Interrupt sources gated by their enables
  assign irqAny = (control_one_r[`C1_RIE] && rxDataAvail)
      || (control_one_r[`C1_TIE] && txFifoAvail)
      || (control_two_r[`C2_EIE] && (parityError || rxOverrun_r
          || txUnderflow_r || ctsLatch_r || dcdLatch_r));

  // Status image; latched bits OR the live pin level
  assign status = {irqOe, parityError, rxOverrun_r, txUnderflow_r,
                   ctsLatch_r || pin_r.clearToSendIn,
                   dcdLatch_r || pin_r.carrierDetect,
                   txFifoAvail, rxDataAvail};

  // Read data driven while the strobe is high; status reads clear no flag
  always_ff @(posedge clk) begin
    if (rst) begin
      dataOut <= 8'h00;
      dataOe <= 1'b0;
    end else if (ce) begin
      dataOe <= pin_r.busEnable && !pin_r.chipSelectN
                && pin_r.readNotWrite;
      if (pin_r.registerSelect) begin
        dataOut <= rxFifo_r.data[`STAGE_N-1][7:0];
      end else begin
        dataOut <= status;
      end
    end
  end

  // Open drain: pull low while any enabled source is set
  always_ff @(posedge clk) begin
    if (rst) begin
      irqOut <= 1'b0;
      irqOe <= 1'b0;
    end else if (ce) begin
      irqOut <= 1'b0;
      irqOe <= irqAny;
    end
  end

  // Underflow pin ends on the falling transmit clock edge
  always_ff @(posedge clk) begin
    if (rst) begin
      underflowOut <= 1'b0;
    end else if (ce) begin
      if (underflowEv && control_two_r[`C2_FILL]) begin
        underflowOut <= 1'b1;
      end else if (pinPrev_r.txClk && !pin_r.txClk) begin
        underflowOut <= 1'b0;
      end
    end
  end

  // Match pulse lasts until the next receive clock rise
  always_ff @(posedge clk) begin
    if (rst) begin
      smPulse_r <= 1'b0;
    end else if (ce) begin
      if (syncMatch && pcSel == `PC_PULSE) begin
        smPulse_r <= 1'b1;
      end else if (pin_r.rxClk && !pinPrev_r.rxClk) begin
        smPulse_r <= 1'b0;
      end
    end
  end

  // Pin level per output control code
  always_ff @(posedge clk) begin
    if (rst) begin
      matchOrTermReadyOut <= 1'b1;
    end else if (ce) begin
      unique case (pcSel)
        `PC_HIGH: matchOrTermReadyOut <= 1'b1;
        `PC_PULSE: matchOrTermReadyOut <= smPulse_r;
        `PC_LOW: matchOrTermReadyOut <= 1'b0;
        `PC_INHIBIT: matchOrTermReadyOut <= 1'b0;
      endcase
    end
  end

  // Shifter sees the buffer's room; overrun when it has none
  assign rxCharReady = bufReady;

endmodule

`default_nettype wire

// >>> src/serial_adapter_params.svh
// Constants of the synchronous serial adapter: selects, fields, resets.
// Included by the package and the design file; definitions only.
`ifndef SERIAL_ADAPTER_PARAMS_SVH
`define SERIAL_ADAPTER_PARAMS_SVH

// Sizes
`define BYTE_W 8
`define STAGE_N 3
`define BUF_DEPTH 4

// Address control codes for writes with register select high
`define AC_FORMAT 2'h0
`define AC_SYNCMODE 2'h1
`define AC_SYNCCODE 2'h2
`define AC_TXDATA 2'h3

// Status bit positions
`define ST_RDA 0
`define ST_TX_FIFO_AVAIL 1
`define ST_DCD 2
`define ST_CTS 3
`define ST_TUF 4
`define ST_OVR 5
`define ST_PE 6
`define ST_IRQ 7

// Primary control bit positions
`define C1_AC_HI 7
`define C1_AC_LO 6
`define C1_RIE 5
`define C1_TIE 4
`define C1_CLRSYNC 3
`define C1_STRIP 2
`define C1_TXRST 1
`define C1_RXRST 0

// Format control bit positions
`define C2_EIE 7
`define C2_FILL 6
`define C2_WS_HI 5
`define C2_WS_LO 3
`define C2_ONEBYTE 2
`define C2_PC_HI 1
`define C2_PC_LO 0

// Sync mode control bit positions
`define C3_CLRUF 3
`define C3_CLRCTS 2
`define C3_ONESYNC 1
`define C3_EXTSYNC 0

// Reset values: both sections start held in reset
`define C1_RESET 8'h03
`define C2_RESET 8'h00
`define C3_RESET 8'h00
`define SYNC_RESET 8'h00

// Word length select codes with seven and eight bits and no parity
`define WS_SEVEN_NP 3'h2
`define WS_EIGHT_NP 3'h3

// Output control codes for the match / terminal ready pin
`define PC_HIGH 2'h0
`define PC_PULSE 2'h1
`define PC_LOW 2'h2
`define PC_INHIBIT 2'h3

// Fill character when sync fill is off
`define MARK_CHAR 8'hff

`endif

// >>> src/serial_adapter_pkg.sv
// Types shared by the serial adapter design and its bench.
// Assumes the constants header sits beside it on the include path.
`include "serial_adapter_params.svh"
`default_nettype none

package serial_adapter_pkg;

  // All pins from outside the clock domain, synchronised together
  typedef struct packed {
    logic busEnable;
    logic chipSelectN;
    logic registerSelect;
    logic readNotWrite;
    logic [`BYTE_W-1:0] dataIn;
    logic txClk;
    logic rxClk;
    logic carrierDetect;
    logic clearToSendIn;
  } pins_t;

  // Three staged FIFO registers; bit 8 of rx data is its parity fault
  typedef struct packed {
    logic [`STAGE_N-1:0] full;
    logic [`STAGE_N-1:0][`BYTE_W:0] data;
  } stages_t;

  // Character from the receive shifter
  typedef struct packed {
    logic [`BYTE_W-1:0] data;
    logic parityBit;
    logic isSync;
  } rxChar_t;

  // Settings handed to the shifters and sync search
  typedef struct packed {
    logic txHoldReset;
    logic rxHoldReset;
    logic clearSync;
    logic stripSync;
    logic [2:0] wordSel;
    logic oneSync;
    logic extSync;
    logic fillWithSync;
    logic [`BYTE_W-1:0] syncCode;
  } linkCtl_t;

endpackage

`default_nettype wire

// >>> bench/sync_serial_adapter_props.sv
// Assertions on the serial adapter's top-level ports.
// Bound into every adapter instance; one clock domain.
`default_nettype none
module sync_serial_adapter_props (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Host bus
  input wire logic busEnable,
  input wire logic chipSelectN,
  input wire logic readNotWrite,
  input wire logic dataOe,
  input wire logic irqOe,
  // Link side
  input wire logic txTake,
  input wire logic underflowOut,
  input wire logic matchOrTermReadyOut,
  input wire logic [7:0] txCharOut,
  input wire serial_adapter_pkg::linkCtl_t linkCtl
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // Strobe phases as seen at the raw pins
  sequence readStrobe;
    busEnable && !chipSelectN && readNotWrite ##1 busEnable[*5];
  endsequence
  sequence strobeEnded;
    busEnable ##1 !busEnable[*5];
  endsequence

  reset_state_a: assert property ($fell(rst) |->
    linkCtl.txHoldReset && linkCtl.rxHoldReset && !dataOe && !irqOe &&
    !underflowOut && matchOrTermReadyOut && txCharOut == 8'hff)
    else $error("Outputs wrong after reset");
  read_answer_a: assert property (readStrobe |-> dataOe)
    else $error("Read strobe not answered");
  read_release_a: assert property (strobeEnded |-> !dataOe)
    else $error("Bus still driven after strobe");
  ctl_write_a: assert property ($changed(linkCtl.wordSel) |->
    !$past(busEnable, 2) && !$past(readNotWrite, 2))
    else $error("Format changed without a write");
  clr_sync_a: assert property (linkCtl.clearSync |=>
    !linkCtl.clearSync) else $error("Clear sync longer than a cycle");
  uf_cause_a: assert property ($rose(underflowOut) |->
    $past(txTake) && $past(linkCtl.fillWithSync))
    else $error("Underflow pulse without cause");
  uf_fill_a: assert property ($rose(underflowOut) |->
    txCharOut == linkCtl.syncCode) else $error("Fill is not sync code");
  uf_hold_a: assert property (txTake && linkCtl.txHoldReset |=>
    !$rose(underflowOut)) else $error("Underflow while held");
  tx_char_a: assert property ($changed(txCharOut) |->
    $past(txTake)) else $error("Character changed without a take");
endmodule

bind sync_serial_adapter sync_serial_adapter_props chk (.clk, .rst,
  .busEnable, .chipSelectN, .readNotWrite, .dataOe, .irqOe, .txTake,
  .underflowOut, .matchOrTermReadyOut, .txCharOut, .linkCtl);
`default_nettype wire

// >>> bench/adapter_host_model.sv
// Host processor model: one register access per bus strobe.
// Assumes the bench clock; pins change only at its falling edge.
`default_nettype none
module adapter_host_model (
  // Clock
  input wire logic clk,
  // Bus pins towards the adapter
  output logic busEnable,
  output logic chipSelectN,
  output logic registerSelect,
  output logic readNotWrite,
  output logic [7:0] dataIn,
  // Read data back
  input wire logic [7:0] dataOut
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle bus: strobe low, chip not selected
  initial begin
    busEnable = 1'b0;
    chipSelectN = 1'b1;
    registerSelect = 1'b0;
    readNotWrite = 1'b1;
    dataIn = 8'h00;
  end

  // Pins settle a cycle before the strobe and stay past its fall
  task automatic acc(input logic rs, input logic rnw,
                     input logic [7:0] d, output logic [7:0] q);
    @(negedge clk);
    chipSelectN = 1'b0;
    registerSelect = rs;
    readNotWrite = rnw;
    dataIn = rnw ? ~dataIn : d; // Undriven bus shows no stale byte
    @(negedge clk);
    busEnable = 1'b1;
    repeat (8) @(negedge clk);
    q = dataOut;
    busEnable = 1'b0;
    repeat (6) @(negedge clk);
    chipSelectN = 1'b1;
  endtask
endmodule
`default_nettype wire

// >>> bench/sync_serial_adapter_tb_top.sv
// Self-checking bench for the serial adapter status and control.
// Assumes design, host model and checker are compiled first.
`default_nettype none
`define CHK(got, exp) begin testsRun++; if ((got) !== (exp)) begin \
  failCount++; $display("ERROR t=%0t got=%h exp=%h", $time, got, exp); \
  end end

module sync_serial_adapter_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  // Access: {select, read}, data, read mask, expected read value
  typedef struct packed {
    logic [1:0] sel;
    logic [7:0] d;
    logic [7:0] m;
    logic [7:0] e;
  } row_t;
  localparam row_t ROWS [18] = '{
    26'h100ff00, 26'h0000000, 26'h25c0000, 26'h100ff02,
    26'h0100000, 26'h100ff82, 26'h0800000, 26'h23c0000,
    26'h0c20000, 26'h2a10000, 26'h1000200, 26'h2b20000,
    26'h1000200, 26'h2c30000, 26'h1000200, 26'h1000200,
    26'h0c00000, 26'h1000200};

  logic clk = 1'b0, rst = 1'b1, txClk = 1'b0, rxClk = 1'b0;
  logic carrierDetect = 1'b0, clearToSendIn = 1'b0, syncMatch = 1'b0;
  logic rxCharValid = 1'b0, txTake = 1'b0;
  serial_adapter_pkg::rxChar_t rxChar = '0;
  logic busEnable, chipSelectN, registerSelect, readNotWrite;
  logic dataOe, irqOut, irqOe, underflowOut, rxCharReady;
  logic matchOrTermReadyOut;
  logic [7:0] dataIn, dataOut, txCharOut, q;
  serial_adapter_pkg::linkCtl_t linkCtl;
  int failCount = 0, testsRun = 0;

  // Link clocks unrelated in phase to the core clock
  always #2.5 clk = ~clk;
  always #32 txClk = ~txClk;
  always #32 rxClk = ~rxClk;

  adapter_host_model host (.clk(clk), .busEnable(busEnable),
    .chipSelectN(chipSelectN), .registerSelect(registerSelect),
    .readNotWrite(readNotWrite), .dataIn(dataIn), .dataOut(dataOut));
  sync_serial_adapter uut (.clk(clk), .rst(rst), .ce(1'b1),
    .busEnable(busEnable), .chipSelectN(chipSelectN),
    .registerSelect(registerSelect), .readNotWrite(readNotWrite),
    .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe),
    .irqOut(irqOut), .irqOe(irqOe), .txClk(txClk), .rxClk(rxClk),
    .carrierDetect(carrierDetect), .clearToSendIn(clearToSendIn),
    .underflowOut(underflowOut),
    .matchOrTermReadyOut(matchOrTermReadyOut),
    .rxCharValid(rxCharValid), .rxChar(rxChar),
    .rxCharReady(rxCharReady), .syncMatch(syncMatch),
    .txTake(txTake), .txCharOut(txCharOut), .linkCtl(linkCtl));

  task automatic tallyAndFinish();
    $display("Checks %0d, mismatches %0d", testsRun, failCount);
    if (failCount == 0 && testsRun > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic wr(input logic rs, input logic [7:0] d);
    host.acc(rs, 1'h0, d, q);
  endtask
  task automatic rd(input logic rs, input logic [7:0] m, e);
    host.acc(rs, 1'h1, 8'h00, q);
    `CHK(q & m, e)
  endtask
  task automatic pulseTake();
    @(posedge txClk);
    @(negedge clk) txTake = 1'b1;
    @(negedge clk) txTake = 1'b0;
    @(negedge clk);
  endtask
  task automatic take(input logic [7:0] e, input logic uf);
    pulseTake();
    `CHK(txCharOut, e)
    `CHK(underflowOut, uf)
  endtask
  // One character in, then three strobes to reach the last stage
  task automatic rxSend(input logic [7:0] d, input logic sync);
    @(negedge clk);
    rxChar = {d, 1'b0, sync};
    rxCharValid = 1'b1;
    @(negedge clk) rxCharValid = 1'b0;
    repeat (3) host.acc(1'h0, 1'h1, 8'h00, q);
  endtask

  // Watchdog: about twenty times the expected run
  initial begin
    #100000;
    failCount++;
    tallyAndFinish();
  end

  initial begin
    repeat (4) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    for (int i = 0; i < 18; i++) begin
      host.acc(ROWS[i].sel[1], ROWS[i].sel[0], ROWS[i].d, q);
      if (ROWS[i].sel[0]) `CHK(q & ROWS[i].m, ROWS[i].e)
    end
    // Preloaded characters leave in order, then sync fill
    take(8'ha1, 1'b0);
    host.acc(1'h0, 1'h1, 8'h00, q);
    take(8'hb2, 1'b0);
    host.acc(1'h0, 1'h1, 8'h00, q);
    take(8'hc3, 1'b0);
    take(8'h3c, 1'b1);
    @(negedge txClk);
    repeat (4) @(negedge clk);
    `CHK(underflowOut, 1'b0)
    rd(1'h0, 8'h10, 8'h10);
    wr(1'h0, 8'h40);
    wr(1'h1, 8'h08);
    rd(1'h0, 8'h10, 8'h00);
    // Held transmitter flags no underflow on a take; mark fill when sync fill off
    wr(1'h0, 8'h42);
    pulseTake();
    `CHK(underflowOut, 1'b0)
    wr(1'h0, 8'h00);
    wr(1'h1, 8'h1c);
    take(8'hff, 1'b0);
    rd(1'h0, 8'h10, 8'h00);
    // Clear-to-send latch and its hold on transmit avail
    clearToSendIn = 1'b1;
    rd(1'h0, 8'h0a, 8'h08);
    clearToSendIn = 1'b0;
    rd(1'h0, 8'h08, 8'h08);
    wr(1'h0, 8'h40);
    wr(1'h1, 8'h04);
    rd(1'h0, 8'h0a, 8'h02);
    wr(1'h1, 8'h01);
    clearToSendIn = 1'b1;
    rd(1'h0, 8'h02, 8'h02);
    clearToSendIn = 1'b0;
    // Carrier edge stays until status then data are read
    carrierDetect = 1'b1;
    rxSend(8'h5a, 1'b0);
    carrierDetect = 1'b0;
    rd(1'h0, 8'h05, 8'h05);
    rd(1'h1, 8'hff, 8'h5a);
    rd(1'h0, 8'h05, 8'h00);
    // Stripped sync character never reaches the last stage
    wr(1'h0, 8'h0c);
    rxSend(8'h3c, 1'b1);
    rd(1'h0, 8'h01, 8'h00);
    // Match pin under every output control code
    wr(1'h0, 8'h00);
    for (int pc = 0; pc < 4; pc++) begin
      wr(1'h1, 8'h1c | 8'(pc));
      if (pc == 1) begin
        @(negedge rxClk);
        @(negedge clk) syncMatch = 1'b1;
        @(negedge clk) syncMatch = 1'b0;
        repeat (2) @(negedge clk);
        `CHK(matchOrTermReadyOut, 1'b1)
        @(posedge rxClk);
        repeat (5) @(negedge clk);
        `CHK(matchOrTermReadyOut, 1'b0)
      end else `CHK(matchOrTermReadyOut, 1'(pc == 0))
    end
    // Parity fault, two-byte avail, then overrun
    wr(1'h1, 8'h30);
    rxSend(8'h01, 1'b0);
    rd(1'h0, 8'h41, 8'h40);
    rxSend(8'h03, 1'b0);
    rd(1'h0, 8'h41, 8'h41);
    rd(1'h1, 8'hff, 8'h01);
    rd(1'h0, 8'h41, 8'h00);
    rxCharValid = 1'b1;
    repeat (5) @(negedge clk);
    rxCharValid = 1'b0;
    `CHK(rxCharReady, 1'b0)
    rd(1'h0, 8'h20, 8'h20);
    wr(1'h0, 8'h01);
    rd(1'h0, 8'h20, 8'h00);
    // Second reset in mid-run
    rst = 1'b1;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    `CHK(txCharOut, 8'hff)
    rd(1'h0, 8'h02, 8'h00);
    `CHK(irqOut, 1'b0)
    tallyAndFinish();
  end
endmodule
`default_nettype wire
